// ===== acmpc_top.sv
/*
 Control and status logic around one analog voltage comparator, with
 an APB slave for its status and control register.
 Assumes the analog comparator delivers its output as an asynchronous
 level, and that system option, clock gate, debug and power mode bits
 arrive as levels from logic on mclk.
*/
// Local design decisions: the placing of the registers and the APB interface to the registers.
// Summary of operation
// - Enable bit 7 starts comparing; while clear the comparator idles unpowered.
// - Bit 6 picks the positive pin or the internal bandgap as plus input.
// - Bit 5 sets on each selected event; writing one clears, zero keeps.
// - Bit 4 enables an interrupt request while the event flag is set.
// - Bit 3 reads the comparator level; zero while disabled.
// - Bit 2 puts the comparator level on the output pin.
// - Bits 1:0 pick falling (00), rising (10) or both edges (11).
// - Output is high when plus input exceeds minus input, else low.
// - Request stands only while interrupt enable and flag are both set.
// - Capture route bit feeds timer channel 0 and takes its pin away.
// - Clock gate bit is set by reset; clearing it freezes the block.
// - In wait mode the comparator runs and its request can wake.
// - In stop3 comparing, pin drive, flag and wake keep working.
// - Leaving stop through reset returns all state to reset values.
// - Stop2 powers the block down; it wakes in reset state.
// - Debug keeps it running; a shared enabled debug pin blocks output.
// - While disabled the two analog pins are freed for digital use.
`include "acmpc_regs.svh"
`default_nettype none

module acmpc_top
   import acmpc_pkg::*;
#(
   parameter int ADDR_W = 12
) (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic comparator_raw,
   input wire logic clock_gate_reg2,
   input wire logic capture_route_select,
   input wire logic debug_pin_enable,
   input wire logic stop2_powerdown,
   output logic comparator_enable,
   output logic reference_select,
   output logic analog_pins_claim,
   output logic comparator_out_pin,
   output logic comparator_out_oe,
   output logic timer_capture_in,
   output logic timer_channel0_release,
   output logic event_irq,
   output logic wake_request
);
   localparam acmpc_state_t ST_RST = '{
      en: 1'(`ACMPC_CSR_RST >> `ACMPC_BIT_EN),
      mode: ACMPC_EDGE_FALL,
      default: 1'b0
   };

   acmpc_state_t q_reg;
   acmpc_state_t q_next;
   logic cmp_sync;
   logic addr_hit;
   logic apb_acc;
   logic csr_wr;
   logic cmp_evt;
   logic [7:0] csr_rd;

   initial begin
      if (ADDR_W < 3) begin
         $error("acmpc_top: ADDR_W must be at least 3");
      end
   end

   // Raw analog output is asynchronous to mclk
   acmpc_sync #(
      .WIDTH(1)
   ) u_sync (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .async_in(comparator_raw),
      .sync_out(cmp_sync)
   );

   function automatic logic edge_hit(input acmpc_edge_t mode, input logic prev,
                                     input logic cur);
      logic hit;
      hit = 1'b0;
      case (mode)
         ACMPC_EDGE_RISE: hit = !prev && cur;
         ACMPC_EDGE_BOTH: hit = prev != cur;
         ACMPC_EDGE_FALL: hit = prev && !cur;
         // Undefined code behaves as falling edge
         default: hit = prev && !cur;
      endcase
      return hit;
   endfunction

   assign addr_hit = paddr[ADDR_W-1:2] == (ADDR_W-2)'(`ACMPC_CSR_OFFS >> 2);
   assign apb_acc = psel && penable && q_reg.pready;
   assign csr_wr = apb_acc && pwrite && addr_hit && clock_gate_reg2;
   // Edges are only judged once a full cycle of enabled history exists
   assign cmp_evt = clock_gate_reg2 && q_reg.en && q_reg.armed
                    && edge_hit(q_reg.mode, q_reg.level, cmp_sync);
   assign csr_rd = {q_reg.en, q_reg.bgs, q_reg.flag, q_reg.ie,
                    q_reg.level, q_reg.ope, q_reg.mode};

   always_comb begin
      q_next = q_reg;
      q_next.pready = psel && !penable;
      if (psel && !penable) begin
         q_next.pslverr = !addr_hit || !clock_gate_reg2;
         q_next.prdata = (addr_hit && clock_gate_reg2) ? {24'h000000, csr_rd} : 32'h00000000;
      end
      // A stopped module clock freezes all comparator state
      if (clock_gate_reg2) begin
         if (csr_wr) begin
            q_next.en = pwdata[`ACMPC_BIT_EN];
            q_next.bgs = pwdata[`ACMPC_BIT_BGS];
            q_next.ie = pwdata[`ACMPC_BIT_IE];
            q_next.ope = pwdata[`ACMPC_BIT_OPE];
            q_next.mode = acmpc_edge_t'(pwdata[`ACMPC_MODE_HI:`ACMPC_MODE_LO]);
            if (pwdata[`ACMPC_BIT_FLAG]) begin
               q_next.flag = 1'b0;
            end
         end
         // Event set wins over a clear in the same cycle
         if (cmp_evt) begin
            q_next.flag = 1'b1;
         end
         q_next.armed = q_reg.en && q_next.en;
         q_next.level = q_next.en ? cmp_sync : 1'b0;
      end
      q_next.irq = q_next.ie && q_next.flag;
      q_next.wake = q_next.ie && q_next.flag;
      // Debug pin owns a shared output pad while enabled
      q_next.out_oe = q_next.en && q_next.ope && !debug_pin_enable;
      q_next.out_pin = q_next.out_oe && q_next.level;
      q_next.ana_en = q_next.en;
      q_next.ref_sel = q_next.en && q_next.bgs;
      q_next.pins_claim = q_next.en;
      q_next.cap_in = capture_route_select && q_next.level;
      q_next.tmr_release = capture_route_select;
      if (stop2_powerdown) begin
         q_next = ST_RST;
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         q_reg <= ST_RST;
      end else begin
         q_reg <= q_next;
      end
   end

   assign prdata = q_reg.prdata;
   assign pready = q_reg.pready;
   assign pslverr = q_reg.pslverr;
   assign comparator_enable = q_reg.ana_en;
   assign reference_select = q_reg.ref_sel;
   assign analog_pins_claim = q_reg.pins_claim;
   assign comparator_out_pin = q_reg.out_pin;
   assign comparator_out_oe = q_reg.out_oe;
   assign timer_capture_in = q_reg.cap_in;
   assign timer_channel0_release = q_reg.tmr_release;
   assign event_irq = q_reg.irq;
   assign wake_request = q_reg.wake;

   property p_flag_set;
      @(posedge mclk) disable iff (sys_rst)
      (cmp_evt && !stop2_powerdown) |=> q_reg.flag;
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("event did not set flag");

   property p_flag_w1c;
      @(posedge mclk) disable iff (sys_rst)
      (csr_wr && pwdata[`ACMPC_BIT_FLAG] && !cmp_evt) |=> !q_reg.flag;
   endproperty
   a_flag_w1c: assert property (p_flag_w1c) else $error("write one did not clear flag");

   property p_flag_hold;
      @(posedge mclk) disable iff (sys_rst)
      (q_reg.flag && !(csr_wr && pwdata[`ACMPC_BIT_FLAG]) && !stop2_powerdown)
         |=> q_reg.flag;
   endproperty
   a_flag_hold: assert property (p_flag_hold) else $error("flag lost without clear");

   property p_irq_on;
      @(posedge mclk) disable iff (sys_rst)
      (q_reg.ie && q_reg.flag && !csr_wr && !stop2_powerdown) |=> event_irq;
   endproperty
   a_irq_on: assert property (p_irq_on) else $error("request missing");

   property p_irq_only;
      @(posedge mclk) disable iff (sys_rst)
      event_irq |-> (q_reg.ie && q_reg.flag);
   endproperty
   a_irq_only: assert property (p_irq_only) else $error("request without cause");

   property p_level_off;
      @(posedge mclk) disable iff (sys_rst)
      !q_reg.en |-> (!q_reg.level && !csr_rd[`ACMPC_BIT_LEVEL]);
   endproperty
   a_level_off: assert property (p_level_off) else $error("level seen while disabled");

   property p_no_cmp_off;
      @(posedge mclk) disable iff (sys_rst)
      (!q_reg.en && !q_reg.flag && !csr_wr) |=> (!q_reg.flag && !comparator_enable);
   endproperty
   a_no_cmp_off: assert property (p_no_cmp_off) else $error("disabled block compared");

   property p_rise;
      @(posedge mclk) disable iff (sys_rst)
      (clock_gate_reg2 && q_reg.en && q_reg.armed && q_reg.mode == ACMPC_EDGE_RISE
       && !q_reg.level && cmp_sync && !stop2_powerdown) |=> q_reg.flag;
   endproperty
   a_rise: assert property (p_rise) else $error("rising edge missed");

   property p_pin;
      @(posedge mclk) disable iff (sys_rst)
      comparator_out_oe |-> (q_reg.en && q_reg.ope && $past(!debug_pin_enable));
   endproperty
   a_pin: assert property (p_pin) else $error("pin driven when not allowed");

   property p_route;
      @(posedge mclk) disable iff (sys_rst)
      (capture_route_select && !stop2_powerdown) |=> timer_channel0_release;
   endproperty
   a_route: assert property (p_route) else $error("timer pin not released");

   property p_stop2;
      @(posedge mclk) disable iff (sys_rst)
      stop2_powerdown |=> (!q_reg.en && !q_reg.flag && !event_irq && !comparator_out_oe);
   endproperty
   a_stop2: assert property (p_stop2) else $error("stop2 left state behind");

   property p_apb_ready;
      @(posedge mclk) disable iff (sys_rst)
      (psel && !penable) |=> (pready ##1 !pready);
   endproperty
   a_apb_ready: assert property (p_apb_ready) else $error("apb ready timing wrong");

   property p_pins;
      @(posedge mclk) disable iff (sys_rst)
      analog_pins_claim |-> q_reg.en;
   endproperty
   a_pins: assert property (p_pins) else $error("pins held while disabled");

   c_rise_evt: cover property (@(posedge mclk) disable iff (sys_rst)
      cmp_evt && q_reg.mode == ACMPC_EDGE_RISE);
   c_both_evt: cover property (@(posedge mclk) disable iff (sys_rst)
      cmp_evt && q_reg.mode == ACMPC_EDGE_BOTH);
   c_irq: cover property (@(posedge mclk) disable iff (sys_rst) $rose(event_irq));
   c_set_clear: cover property (@(posedge mclk) disable iff (sys_rst)
      cmp_evt && csr_wr && pwdata[`ACMPC_BIT_FLAG]);
endmodule

`default_nettype wire

// ===== acmpc_regs.svh
/*
 Register offsets, field positions, reset values and counts of the
 comparator control block. Assumes a 32-bit APB with one aligned word
 per register.
*/
`ifndef ACMPC_REGS_SVH
`define ACMPC_REGS_SVH

`define ACMPC_CSR_OFFS 12'h000
`define ACMPC_CSR_RST 8'h00
`define ACMPC_BIT_EN 7
`define ACMPC_BIT_BGS 6
`define ACMPC_BIT_FLAG 5
`define ACMPC_BIT_IE 4
`define ACMPC_BIT_LEVEL 3
`define ACMPC_BIT_OPE 2
`define ACMPC_MODE_HI 1
`define ACMPC_MODE_LO 0
`define ACMPC_SYNC_STAGES 2

`endif

// ===== acmpc_pkg.sv
/*
 Types of the comparator control block: edge mode encoding and the
 packed state record. Assumes acmpc_regs.svh for the numbers.
*/
`default_nettype none

package acmpc_pkg;

   typedef enum logic [1:0] {
      ACMPC_EDGE_FALL = 2'b00,
      ACMPC_EDGE_RSVD = 2'b01,
      ACMPC_EDGE_RISE = 2'b10,
      ACMPC_EDGE_BOTH = 2'b11
   } acmpc_edge_t;

   typedef struct packed {
      logic en;
      logic bgs;
      logic flag;
      logic ie;
      logic level;
      logic ope;
      acmpc_edge_t mode;
      logic armed;
      logic irq;
      logic wake;
      logic out_pin;
      logic out_oe;
      logic ana_en;
      logic ref_sel;
      logic pins_claim;
      logic cap_in;
      logic tmr_release;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } acmpc_state_t;

endpackage

`default_nettype wire

// ===== acmpc_sync.sv
/*
 Two-stage synchroniser for asynchronous levels.
 Assumes the input is a static level from outside the mclk domain.
*/
`default_nettype none

module acmpc_sync #(
   parameter int WIDTH = 1
) (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_reg;

   initial begin
      if (WIDTH < 1) begin
         $error("acmpc_sync: WIDTH must be at least 1");
      end
   end

   // The first stage feeds only the second stage
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         meta_reg <= '0;
         sync_out <= '0;
      end else begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end
endmodule

`default_nettype wire

// ===== acmpc_analog_model.sv
/*
 Behavioural model of the analog comparator behind the control block.
 Assumes the bench sets the input levels in millivolts off the clock edge.
*/
`default_nettype none

module acmpc_analog_model (
   input wire logic mclk,
   input wire logic powered,
   input wire logic bandgap_sel,
   input wire logic [15:0] plus_mv,
   input wire logic [15:0] minus_mv,
   input wire logic [15:0] bandgap_mv,
   output logic cmp_out
);
   timeunit 1ns;
   timeprecision 1ps;

   initial cmp_out = 1'b0;

   // Unpowered output wanders, so the block must not trust it
   always @(posedge mclk) begin
      if (!powered) begin
         cmp_out <= ~cmp_out;
      end else begin
         cmp_out <= ((bandgap_sel ? bandgap_mv : plus_mv) > minus_mv);
      end
   end
endmodule

`default_nettype wire

// ===== acmpc_tb.sv
/*
 Self-checking bench for the comparator control block over APB.
 Assumes the analog model stands in for the comparator output.
*/
`include "acmpc_regs.svh"
`default_nettype none

module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import acmpc_pkg::*;

   localparam logic [7:0] EN = 8'h80, BGS = 8'h40, FLG = 8'h20, IE = 8'h10;
   localparam logic [7:0] LVL = 8'h08, OPE = 8'h04;
   logic mclk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr, raw, gate = 1, route = 0, dbg = 0, stop2 = 0;
   logic en_o, ref_o, claim, pin, oe, cap, rel, irq, wake;
   logic [15:0] pos = 16'h0064, neg = 16'h01F4, bg = 16'h0064;
   int failures = 0, compares = 0;

   always #4 mclk = ~mclk;

   acmpc_top dut (.mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .comparator_raw(raw), .clock_gate_reg2(gate),
      .capture_route_select(route), .debug_pin_enable(dbg), .stop2_powerdown(stop2),
      .comparator_enable(en_o), .reference_select(ref_o), .analog_pins_claim(claim),
      .comparator_out_pin(pin), .comparator_out_oe(oe), .timer_capture_in(cap),
      .timer_channel0_release(rel), .event_irq(irq), .wake_request(wake));

   acmpc_analog_model model (.mclk(mclk), .powered(en_o), .bandgap_sel(ref_o),
      .plus_mv(pos), .minus_mv(neg), .bandgap_mv(bg), .cmp_out(raw));

   task summarize;
      $display("failures %0d compares %0d", failures, compares);
      if (failures == 0 && compares > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task tick(input int n);
      repeat (n) @(negedge mclk);
   endtask

   // Request held until pready is seen high; data taken in that cycle
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
            output logic [31:0] q, output logic e);
      int n;
      n = 0;
      @(posedge mclk);
      psel <= 1;
      penable <= 0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1;
      // pready is sampled at the rising edge, before this edge updates it
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         failures++;
         summarize();
      end
      q = prdata;
      e = pslverr;
      psel <= 0;
      penable <= 0;
   endtask

   task wr(input logic [7:0] d);
      logic [31:0] q;
      logic e;
      apb(1, `ACMPC_CSR_OFFS, {24'h0, d}, q, e);
   endtask

   task rd(input logic [7:0] exp, input logic experr);
      logic [31:0] q;
      logic e;
      apb(0, `ACMPC_CSR_OFFS, 32'h0, q, e);
      chk(q, experr ? 32'h0 : {24'h0, exp});
      chk(e, experr);
   endtask

   task sc_modes;
      logic [7:0] m;
      for (int i = 0; i < 4; i++) begin
         m = i[7:0];
         pos <= 16'h0064;
         wr(EN | m);
         tick(6);
         wr(EN | m | FLG);
         rd(EN | m, 0);
         pos <= 16'h0384;
         tick(6);
         rd(EN | m | LVL | (m[1] ? FLG : 8'h00), 0);
         wr(EN | m | FLG);
         pos <= 16'h0064;
         tick(6);
         wr(EN | m);
         rd(EN | m | ((m != 2) ? FLG : 8'h00), 0);
      end
   endtask

   task sc_irq;
      wr(EN | IE | 8'h02 | FLG);
      tick(1);
      chk(irq, 0);
      pos <= 16'h0384;
      tick(6);
      chk({irq, wake}, 2'b11);
      wr(EN | 8'h02);
      tick(2);
      chk(irq, 0);
      wr(EN | IE | 8'h02);
      tick(2);
      chk(irq, 1);
      wr(EN | IE | 8'h02 | FLG);
      tick(2);
      chk({irq, wake}, 2'b00);
      wr(8'h00);
      tick(4);
      chk({en_o, claim}, 2'b00);
      rd(8'h00, 0);
   endtask

   task sc_ref;
      pos <= 16'h0064;
      bg <= 16'h0384;
      wr(EN | BGS);
      tick(6);
      chk({en_o, ref_o, claim}, 3'b111);
      // Unpowered comparator output may leave a stray event behind
      wr(EN | BGS | FLG);
      rd(EN | BGS | LVL, 0);
      bg <= 16'h0064;
      tick(6);
      rd(EN | BGS | FLG, 0);
   endtask

   task sc_pin;
      pos <= 16'h0384;
      wr(EN | OPE | FLG);
      tick(6);
      chk({oe, pin}, 2'b11);
      @(posedge mclk);
      dbg <= 1;
      tick(3);
      chk(oe, 0);
      @(posedge mclk);
      dbg <= 0;
      route <= 1;
      tick(3);
      chk({cap, rel}, 2'b11);
      @(posedge mclk);
      route <= 0;
      tick(3);
      chk({cap, rel}, 2'b00);
      wr(EN);
      tick(2);
      chk({oe, pin}, 2'b00);
   endtask

   task sc_err;
      logic [31:0] q;
      logic e;
      apb(0, 12'h004, 32'h0, q, e);
      chk(q, 32'h0);
      chk({31'h0, e}, 32'h1);
      gate <= 0;
      wr(8'h00);
      rd(8'h00, 1);
      gate <= 1;
      rd(EN | LVL, 0);
   endtask

   task sc_stop2;
      wr(EN | IE | OPE);
      stop2 <= 1;
      tick(2);
      @(posedge mclk);
      stop2 <= 0;
      rd(8'h00, 0);
      chk({en_o, ref_o, claim, pin, oe, irq, wake}, 7'h00);
   endtask

   initial begin
      repeat (16) @(posedge mclk);
      sys_rst <= 0;
      tick(1);
      chk({en_o, claim, oe, cap, irq, wake, pready, pslverr}, 8'h00);
      rd(`ACMPC_CSR_RST, 0);
      sc_modes();
      sc_irq();
      sc_ref();
      sc_pin();
      sc_err();
      sc_stop2();
      summarize();
   end
endmodule

`default_nettype wire
